// ### design/hbh_pkg.sv
// constants, states and rule summary for the host bus handshake port
// Contract
// [R1] sync mode: ready falls on bus clock
// [R2] burst mode: ready low during wait states
// [R3] irq low while any status set
// [R4] select when qualifier low, address matches
// [R5] select decode purely combinational
// [R6] async ready stretches cycles, clock independent
// [R7] host marks command phase after address
// [R8] burst: cycle high read, low write
// [R9] strap low sync, high async/burst
// [R10] host async read strobe, clockless
// [R11] host returns ready, else tie asserted
// [R12] host bus clock max 50 MHz; port oversamples it on a 100 ns clock, so it must run well below 10 MHz
// [R13] host drives qualifier low to decode
// [R14] host write/read high write, low read
// [R15] irq and async ready only low/released
package hbh_pkg;

  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 4;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;

  localparam int CLK_PERIOD_NS = 100;
  // bus clock counted as stopped after this long without a rising edge
  localparam int BCLK_IDLE_NS = 2000;
  localparam int BCLK_IDLE_CYC = (BCLK_IDLE_NS / CLK_PERIOD_NS) < 1 ? 1 : (BCLK_IDLE_NS / CLK_PERIOD_NS);
  localparam int IDLE_CNT_W = $clog2(BCLK_IDLE_CYC + 1);

  localparam int SYNC_STAGES = 2;

  localparam logic PIN_HIGH = 1'b1;
  localparam logic PIN_LOW = 1'b0;

  // index of each pin in the synchroniser vector
  localparam int PI_AQN = ADDR_W;
  localparam int PI_CYC = ADDR_W + 1;
  localparam int PI_SWR = ADDR_W + 2;
  localparam int PI_RRT = ADDR_W + 3;
  localparam int PI_RDN = ADDR_W + 4;
  localparam int PI_WRN = ADDR_W + 5;
  localparam int PI_STRAP = ADDR_W + 6;
  localparam int PI_BCLK = ADDR_W + 7;
  localparam int PIN_W = ADDR_W + 8;

  typedef enum logic [5:0] {
    ST_IDLE       = 6'b00_0001,
    ST_SYNC_WAIT  = 6'b00_0010,
    ST_SYNC_READY = 6'b00_0100,
    ST_BURST      = 6'b00_1000,
    ST_ASYNC_WAIT = 6'b01_0000,
    ST_ASYNC_END  = 6'b10_0000
  } hbh_state_t;

endpackage

// ### design/hbh_sync.sv
// two flip-flop synchroniser for a vector of independent pin levels
`timescale 1ns/1ps
module hbh_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  import hbh_pkg::*;

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("hbh_sync: WIDTH must be at least 1");
    end
  end

  // bits are synchronised independently; multi-bit values must be stable around sampling
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// ### design/hbh_port.sv
// handshake, qualifier, strap and interrupt logic of the host bus port
`timescale 1ns/1ps
module hbh_port #(
  parameter int IRQ_W = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic BUS_CLK_I,
  input wire logic [hbh_pkg::ADDR_HI:hbh_pkg::ADDR_LO] ADDR_I,
  input wire logic ADDRESS_QUALIFIER_N_I,
  input wire logic COMMAND_PHASE_N_I,
  input wire logic SYNC_WRITE_NOT_READ_I,
  input wire logic READY_RETURN_IN_N_I,
  input wire logic ASYNC_READ_STROBE_N_I,
  input wire logic ASYNC_WRITE_STROBE_N_I,
  input wire logic BUS_MODE_STRAP_I,
  input wire logic [hbh_pkg::ADDR_HI:hbh_pkg::ADDR_LO] BASE_ADDR_HI_I,
  input wire logic [IRQ_W-1:0] IRQ_STATUS_I,
  input wire logic ACCESS_DONE_I,
  output logic LOCAL_DEVICE_SELECT_N_O,
  output logic SYNC_READY_OUT_N_O,
  output logic HOST_IRQ_OUT_N_O,
  output logic HOST_IRQ_OUT_N_OE_O,
  output logic ASYNC_CYCLE_READY_O,
  output logic ASYNC_CYCLE_READY_OE_O,
  output logic MODE_SYNC_O,
  output logic ACCESS_REQ_O,
  output logic ACCESS_WRITE_O
);
  import hbh_pkg::*;

  initial begin
    if (IRQ_W < 1) begin
      $error("hbh_port: IRQ_W must be at least 1");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local device decode

  // the select output is a pure decode of the live pins, no flop and no clock
  always_comb begin
    LOCAL_DEVICE_SELECT_N_O = PIN_HIGH;
    if (!ADDRESS_QUALIFIER_N_I && (ADDR_I == BASE_ADDR_HI_I)) begin // [R4] [R5] [R13]
      LOCAL_DEVICE_SELECT_N_O = PIN_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;

  assign pins_raw = {BUS_CLK_I, BUS_MODE_STRAP_I, ASYNC_WRITE_STROBE_N_I, ASYNC_READ_STROBE_N_I,
                     READY_RETURN_IN_N_I, SYNC_WRITE_NOT_READ_I, COMMAND_PHASE_N_I,
                     ADDRESS_QUALIFIER_N_I, ADDR_I};

  hbh_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  logic sel_s;
  logic cyc_n_s;
  logic swr_s;
  logic rrt_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic strap_s;
  logic bclk_s;

  assign sel_s = !pins_s[PI_AQN] && (pins_s[ADDR_W-1:0] == BASE_ADDR_HI_I);
  assign cyc_n_s = pins_s[PI_CYC];
  assign swr_s = pins_s[PI_SWR];
  assign rrt_n_s = pins_s[PI_RRT];
  assign rd_n_s = pins_s[PI_RDN];
  assign wr_n_s = pins_s[PI_WRN];
  assign strap_s = pins_s[PI_STRAP];
  assign bclk_s = pins_s[PI_BCLK];

  ////////////////////////////////////////////////////////////////////////////
  // bus clock edge and activity

  // limitation: the bus clock is oversampled, so it must run well below the system clock
  logic bclk_q;
  logic bclk_rise;
  logic [IDLE_CNT_W-1:0] idle_cnt_q;
  logic bclk_active_q;

  assign bclk_rise = bclk_s && !bclk_q;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bclk_q <= PIN_LOW;
    end else begin
      bclk_q <= bclk_s;
    end
  end

  // a stopped clock (held low in async use) means strobe driven cycles
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      idle_cnt_q <= '0;
      bclk_active_q <= 1'b0;
    end else if (bclk_rise) begin
      idle_cnt_q <= '0;
      bclk_active_q <= 1'b1;
    end else if (idle_cnt_q == IDLE_CNT_W'(BCLK_IDLE_CYC)) begin
      bclk_active_q <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_q + IDLE_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus mode strap

  // the synchroniser reads zero through reset, so the strap is caught only once it shows the pin;
  // a later strap change is ignored
  localparam int STRAP_WAIT_W = $clog2(SYNC_STAGES + 1);
  logic [STRAP_WAIT_W-1:0] strap_wait_q;
  logic strap_taken_q;
  logic mode_sync_q;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      strap_wait_q <= '0;
      strap_taken_q <= 1'b0;
      mode_sync_q <= 1'b1;
    end else if (strap_wait_q != STRAP_WAIT_W'(SYNC_STAGES)) begin
      strap_wait_q <= strap_wait_q + STRAP_WAIT_W'(1);
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      mode_sync_q <= !strap_s; // [R9]
    end
  end

  assign MODE_SYNC_O = mode_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // access state machine

  hbh_state_t state_q;
  hbh_state_t state_d;
  logic ready_ok;
  logic strobe_any;

  // on writes the host gives no ready return, so only reads wait for it
  assign ready_ok = ACCESS_WRITE_O || !rrt_n_s; // [R11]
  assign strobe_any = !rd_n_s || !wr_n_s; // [R10]

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (strap_taken_q && sel_s) begin
          if (mode_sync_q) begin
            if (bclk_rise && !cyc_n_s) begin // [R7]
              state_d = ST_SYNC_WAIT;
            end
          end else if (bclk_active_q) begin
            if (bclk_rise) begin
              state_d = ST_BURST;
            end
          end else if (strobe_any) begin
            state_d = ST_ASYNC_WAIT;
          end
        end
      end
      ST_SYNC_WAIT: begin
        if (ACCESS_DONE_I) begin
          state_d = ST_SYNC_READY;
        end
      end
      ST_SYNC_READY: begin
        if (bclk_rise && !SYNC_READY_OUT_N_O && ready_ok) begin
          state_d = ST_IDLE;
        end
      end
      ST_BURST: begin
        if (ACCESS_DONE_I) begin
          state_d = ST_IDLE;
        end
      end
      ST_ASYNC_WAIT: begin
        if (ACCESS_DONE_I) begin
          state_d = ST_ASYNC_END;
        end
      end
      ST_ASYNC_END: begin
        if (!strobe_any) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request to the core

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ACCESS_REQ_O <= 1'b0;
      ACCESS_WRITE_O <= 1'b0;
    end else begin
      ACCESS_REQ_O <= 1'b0;
      if (state_q == ST_IDLE) begin
        if (state_d == ST_SYNC_WAIT) begin
          ACCESS_REQ_O <= 1'b1;
          ACCESS_WRITE_O <= swr_s; // [R14]
        end else if (state_d == ST_BURST) begin
          ACCESS_REQ_O <= 1'b1;
          ACCESS_WRITE_O <= !cyc_n_s; // [R8]
        end else if (state_d == ST_ASYNC_WAIT) begin
          ACCESS_REQ_O <= 1'b1;
          ACCESS_WRITE_O <= !wr_n_s;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronous ready

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SYNC_READY_OUT_N_O <= PIN_HIGH;
    end else if (state_q == ST_SYNC_READY) begin
      // fall on a bus clock edge, release on the edge that completes the cycle
      if (bclk_rise && SYNC_READY_OUT_N_O) begin
        SYNC_READY_OUT_N_O <= PIN_LOW; // [R1]
      end else if (state_d == ST_IDLE) begin
        SYNC_READY_OUT_N_O <= PIN_HIGH;
      end
    end else if (state_d == ST_BURST) begin
      SYNC_READY_OUT_N_O <= PIN_LOW; // [R2]
    end else begin
      SYNC_READY_OUT_N_O <= PIN_HIGH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open drain outputs

  // both pins only pull low; the board pull-up gives the released level
  assign HOST_IRQ_OUT_N_O = PIN_LOW; // [R15]
  assign ASYNC_CYCLE_READY_O = PIN_LOW; // [R15]

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      HOST_IRQ_OUT_N_OE_O <= 1'b0;
    end else begin
      HOST_IRQ_OUT_N_OE_O <= |IRQ_STATUS_I; // [R3]
    end
  end

  // stretch by pulling the ready pin low from strobe seen until data is done
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ASYNC_CYCLE_READY_OE_O <= 1'b0;
    end else begin
      ASYNC_CYCLE_READY_OE_O <= (state_d == ST_ASYNC_WAIT); // [R6]
    end
  end

endmodule

// ### testbench/hbh_port_assertions.sv
// concurrent checks on the host bus port pins
`timescale 1ns/1ps
module hbh_port_assertions #(
  parameter int IRQ_W = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic [hbh_pkg::ADDR_HI:hbh_pkg::ADDR_LO] ADDR_I,
  input wire logic ADDRESS_QUALIFIER_N_I,
  input wire logic BUS_MODE_STRAP_I,
  input wire logic [hbh_pkg::ADDR_HI:hbh_pkg::ADDR_LO] BASE_ADDR_HI_I,
  input wire logic [IRQ_W-1:0] IRQ_STATUS_I,
  input wire logic ACCESS_DONE_I,
  input wire logic LOCAL_DEVICE_SELECT_N_O,
  input wire logic SYNC_READY_OUT_N_O,
  input wire logic HOST_IRQ_OUT_N_O,
  input wire logic HOST_IRQ_OUT_N_OE_O,
  input wire logic ASYNC_CYCLE_READY_O,
  input wire logic ASYNC_CYCLE_READY_OE_O,
  input wire logic MODE_SYNC_O,
  input wire logic ACCESS_REQ_O
);
  import hbh_pkg::*;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  ////////////////////////////////////////////////////////////////
  sequence s_sync_done;
    MODE_SYNC_O && ACCESS_DONE_I;
  endsequence
  sequence s_burst_go;
    !MODE_SYNC_O && ACCESS_REQ_O && !ASYNC_CYCLE_READY_OE_O;
  endsequence
  property p_sel;
    LOCAL_DEVICE_SELECT_N_O == !(!ADDRESS_QUALIFIER_N_I && ADDR_I == BASE_ADDR_HI_I);
  endproperty
  property p_irq;
    1'b1 |=> HOST_IRQ_OUT_N_OE_O == ($past(IRQ_STATUS_I) != 0);
  endproperty
  property p_od;
    HOST_IRQ_OUT_N_O == 1'b0 && ASYNC_CYCLE_READY_O == 1'b0;
  endproperty
  property p_mode;
    ACCESS_REQ_O |-> MODE_SYNC_O == !BUS_MODE_STRAP_I;
  endproperty
  property p_req;
    ACCESS_REQ_O |=> !ACCESS_REQ_O;
  endproperty
  // bus clock runs through sync accesses, so a bound is fair here
  property p_sync_rdy;
    s_sync_done |-> ##[1:24] $fell(SYNC_READY_OUT_N_O);
  endproperty
  property p_sync_req;
    MODE_SYNC_O && ACCESS_REQ_O |-> SYNC_READY_OUT_N_O;
  endproperty
  property p_burst;
    s_burst_go |-> !SYNC_READY_OUT_N_O;
  endproperty
  property p_burst_end;
    !MODE_SYNC_O && ACCESS_DONE_I && !SYNC_READY_OUT_N_O |=> SYNC_READY_OUT_N_O;
  endproperty
  property p_async;
    ASYNC_CYCLE_READY_OE_O && ACCESS_DONE_I |=> !ASYNC_CYCLE_READY_OE_O;
  endproperty
  a_sel: assert property (p_sel) else $error("select decode wrong");
  a_irq: assert property (p_irq) else $error("irq drive wrong");
  a_od: assert property (p_od) else $error("open drain data high");
  a_mode: assert property (p_mode) else $error("mode differs from strap");
  a_req: assert property (p_req) else $error("request longer than one cycle");
  a_sync_rdy: assert property (p_sync_rdy) else $error("sync ready late");
  a_sync_req: assert property (p_sync_req) else $error("sync ready early");
  a_burst: assert property (p_burst) else $error("burst wait missing");
  a_burst_end: assert property (p_burst_end) else $error("burst wait held");
  a_async: assert property (p_async) else $error("async wait held");
endmodule

// ### testbench/hbh_host_model.sv
// host-side model: bus clock source and ready return
`timescale 1ns/1ps
module hbh_host_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic bus_clk_o,
  output logic ready_return_n_o
);
  logic [2:0] div_q;
  // clock stands low when stopped, as the async mode needs
  always_ff @(posedge clk_i) begin
    if (!run_i)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end
  assign bus_clk_o = div_q[2];
  // a host without ready return keeps it asserted
  assign ready_return_n_o = 1'b0;
endmodule

// ### testbench/hbh_port_bench.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
module hbh_port_bench;
  import hbh_pkg::*;
  logic clk, nrst, run, bclk, rrt_n, aq_n, cyc_n, sync_write_not_read, rd_n, wr_n, strap, done;
  logic sel_n, srdy_n, irq_n, irq_oe, async_cycle_ready, async_cycle_ready_oe, mode_sync, req, wr;
  logic [ADDR_HI:ADDR_LO] addr, base;
  logic [7:0] irq;
  wire irq_pin = irq_oe ? irq_n : 1'b1;
  wire async_cycle_ready_pin = async_cycle_ready_oe ? async_cycle_ready : 1'b1;
  int n_fail = 0;
  int samples_checked = 0;
  int seed;
  hbh_host_model host (.clk_i(clk), .run_i(run), .bus_clk_o(bclk), .ready_return_n_o(rrt_n));
  hbh_port dut (.CLK_SYS_I(clk), .NRST_I(nrst), .BUS_CLK_I(bclk), .ADDR_I(addr),
    .ADDRESS_QUALIFIER_N_I(aq_n), .COMMAND_PHASE_N_I(cyc_n), .SYNC_WRITE_NOT_READ_I(sync_write_not_read),
    .READY_RETURN_IN_N_I(rrt_n), .ASYNC_READ_STROBE_N_I(rd_n), .ASYNC_WRITE_STROBE_N_I(wr_n),
    .BUS_MODE_STRAP_I(strap), .BASE_ADDR_HI_I(base), .IRQ_STATUS_I(irq), .ACCESS_DONE_I(done),
    .LOCAL_DEVICE_SELECT_N_O(sel_n), .SYNC_READY_OUT_N_O(srdy_n), .HOST_IRQ_OUT_N_O(irq_n),
    .HOST_IRQ_OUT_N_OE_O(irq_oe), .ASYNC_CYCLE_READY_O(async_cycle_ready), .ASYNC_CYCLE_READY_OE_O(async_cycle_ready_oe),
    .MODE_SYNC_O(mode_sync), .ACCESS_REQ_O(req), .ACCESS_WRITE_O(wr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  function logic exp_sel();
    return !(!aq_n && addr == base);
  endfunction
  task chk(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // bounded wait at falling edges: 0 for request, 1 for sync ready
  task wait_sig(input int which, input logic v);
    int i;
    i = 0;
    while (((which == 0) ? req : srdy_n) !== v && i < 60) begin
      @(negedge clk);
      i++;
    end
    if (((which == 0) ? req : srdy_n) !== v) begin
      n_fail++;
      $display("BAD %0t wait timed out", $time);
    end
  endtask
  task pulse_done();
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
  task do_reset(input logic s);
    strap = s;
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    // on the first call the model's divider has cleared while run was low, so its clock is known; on the second run stays high
    run = 1'b1;
    nrst = 1'b1;
    repeat (12) @(negedge clk);
    chk(mode_sync, !s, "mode");
  endtask
  task sync_acc(input logic w);
    aq_n = 1'b0;
    addr = base;
    sync_write_not_read = w;
    @(negedge clk);
    cyc_n = 1'b0;
    wait_sig(0, 1'b1);
    chk(wr, w, "sync dir");
    chk(srdy_n, 1'b1, "sync early ready");
    cyc_n = 1'b1;
    aq_n = 1'b1;
    @(negedge clk);
    pulse_done();
    wait_sig(1, 1'b0);
    chk(srdy_n, 1'b0, "sync ready");
    wait_sig(1, 1'b1);
    chk(srdy_n, 1'b1, "sync release");
  endtask
  task burst_acc(input logic w);
    aq_n = 1'b0;
    addr = base;
    cyc_n = !w;
    wait_sig(0, 1'b1);
    chk(wr, w, "burst dir");
    chk(srdy_n, 1'b0, "burst wait");
    aq_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(srdy_n, 1'b0, "burst wait held");
    pulse_done();
    chk(srdy_n, 1'b1, "burst end");
  endtask
  task async_acc(input logic w);
    aq_n = 1'b0;
    addr = base;
    rd_n = w;
    wr_n = !w;
    wait_sig(0, 1'b1);
    chk(async_cycle_ready_oe, 1'b1, "async wait");
    chk(async_cycle_ready_pin, 1'b0, "ready pin low");
    chk(wr, w, "async dir");
    pulse_done();
    chk(async_cycle_ready_pin, 1'b1, "ready pin released");
    rd_n = 1'b1;
    wr_n = 1'b1;
    aq_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    n_fail++;
    final_report();
  end
  initial begin
    seed = 96071;
    {nrst, run, aq_n, cyc_n, sync_write_not_read, rd_n, wr_n, strap, done} = 9'h06c;
    irq = 8'h00;
    base = ADDR_W'($random(seed));
    addr = 12'h000;
    do_reset(1'b0);
    repeat (40) begin
      addr = ($random(seed) & 1) ? base : ADDR_W'($random(seed));
      aq_n = 1'($random(seed));
      irq = ($random(seed) & 1) ? 8'h00 : 8'($random(seed));
      #1;
      chk(sel_n, exp_sel(), "select");
      @(negedge clk);
      chk(irq_oe, irq != 0, "irq drive");
      chk(irq_pin, irq == 0, "irq pin");
    end
    aq_n = 1'b1;
    for (int w = 0; w < 2; w++) begin
      sync_acc(1'(w));
    end
    do_reset(1'b1);
    for (int w = 0; w < 2; w++) begin
      burst_acc(1'(w));
    end
    run = 1'b0;
    repeat (30) @(negedge clk);
    for (int w = 0; w < 2; w++) begin
      async_acc(1'(w));
    end
    final_report();
  end
endmodule
bind hbh_port hbh_port_assertions #(.IRQ_W(IRQ_W)) u_chk (.CLK_SYS_I, .NRST_I, .ADDR_I,
  .ADDRESS_QUALIFIER_N_I, .BUS_MODE_STRAP_I, .BASE_ADDR_HI_I, .IRQ_STATUS_I, .ACCESS_DONE_I,
  .LOCAL_DEVICE_SELECT_N_O, .SYNC_READY_OUT_N_O, .HOST_IRQ_OUT_N_O, .HOST_IRQ_OUT_N_OE_O,
  .ASYNC_CYCLE_READY_O, .ASYNC_CYCLE_READY_OE_O, .MODE_SYNC_O, .ACCESS_REQ_O);
